// File: hdl/rsc_loader.sv
// Reset strap capture and decode for a dual-core processor
//
// Operation
// [R1] Straps captured while master reset is held; configuration follows.
// [R2] Board logic generates master reset locally from its own reset circuitry.
// [R3] Board logic drives straps from switches or fixed board values.
// [R4] Straps with pull-ups read as one when undriven during reset.
// [R5] Platform ratio strap 100 gives platform clock ten times system clock.
// [R6] Core ratio strap 100 runs that core at twice the platform clock.
// [R7] Memory ratio strap 100 gives memory clock ten times reference clock.
// [R8] ROM strap 1111 selects 32-bit local-bus ROM on chip-select machine.
// [R9] Host strap 111 makes the processor root complex on all interfaces.
// [R10] Port strap 1100 selects four-lane serial link, 3.125 Gbps, 125 MHz.
// [R11] Hold-off straps 10: first core boots, second core held off.
// [R12] Sequencer strap 11 disables the boot sequencer; no serial ROM read.
// [R13] Memory type 0 selects DDR2 memory, clock enable low in reset.
// [R14] Controller-enable 0 puts Ethernet ports three and four serial.
// [R15] Ethernet mode strap 0 puts that controller in serial interface mode.
// [R16] Serial lane reference strap 1 selects a 125 MHz reference clock.
// [R17] A 32-bit general vector is captured at reset into a register.
// [R18] Board holds straps stable across reset then releases shared pins.
// [R19] Board may leave pulled-up straps undriven when value equals default.
`timescale 1ns/1ps
module rsc_loader
   import rsc_pkg::*;
(
   // Clock and master reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // Clock ratio straps
   input wire logic [rsc_pkg::RATIO_W-1:0] PLAT_RATIO_STRAP_IN,
   input wire logic [rsc_pkg::RATIO_W-1:0] FIRST_CORE_CLOCK_RATIO_STRAP_IN,
   input wire logic [rsc_pkg::RATIO_W-1:0] SECOND_CORE_CLOCK_RATIO_STRAP_IN,
   input wire logic [rsc_pkg::RATIO_W-1:0] MEM_RATIO_STRAP_IN,
   // Boot and role straps, value plus drive-present flags
   input wire logic [rsc_pkg::ROM_W-1:0] ROM_LOC_STRAP_IN,
   input wire logic [rsc_pkg::ROM_W-1:0] ROM_LOC_DRIVEN_IN,
   input wire logic [rsc_pkg::HOST_W-1:0] HOST_ROLE_STRAP_IN,
   input wire logic [rsc_pkg::HOST_W-1:0] HOST_ROLE_DRIVEN_IN,
   input wire logic [rsc_pkg::PORT_W-1:0] PORT_SEL_STRAP_IN,
   input wire logic [rsc_pkg::PORT_W-1:0] PORT_SEL_DRIVEN_IN,
   input wire logic FIRST_CORE_BOOT_HOLDOFF_STRAP_IN,
   input wire logic SECOND_CORE_BOOT_HOLDOFF_STRAP_IN,
   input wire logic [1:0] HOLDOFF_DRIVEN_IN,
   input wire logic [rsc_pkg::SEQ_W-1:0] BOOT_SEQ_STRAP_IN,
   input wire logic [rsc_pkg::SEQ_W-1:0] BOOT_SEQ_DRIVEN_IN,
   // Memory and Ethernet straps, value plus drive-present flags
   input wire logic MEM_TYPE_STRAP_IN,
   input wire logic MEM_TYPE_DRIVEN_IN,
   input wire logic CTL_EN_STRAP_IN,
   input wire logic CTL_EN_DRIVEN_IN,
   input wire logic ETH1_SERIAL_MODE_STRAP_IN,
   input wire logic ETH2_SERIAL_MODE_STRAP_IN,
   input wire logic ETH3_SERIAL_MODE_STRAP_IN,
   input wire logic ETH4_SERIAL_MODE_STRAP_IN,
   input wire logic [rsc_pkg::ETH_N-1:0] ETH_MODE_DRIVEN_IN,
   input wire logic REFCLK_SEL_STRAP_IN,
   input wire logic REFCLK_SEL_DRIVEN_IN,
   // General configuration vector from local address/data pins
   input wire logic [rsc_pkg::VEC_W-1:0] GEN_VECTOR_IN,
   // Raw captured straps
   output logic [rsc_pkg::RATIO_W-1:0] PLAT_RATIO_OUT,
   output logic [rsc_pkg::RATIO_W-1:0] FIRST_CORE_RATIO_OUT,
   output logic [rsc_pkg::RATIO_W-1:0] SECOND_CORE_RATIO_OUT,
   output logic [rsc_pkg::RATIO_W-1:0] MEM_RATIO_OUT,
   output logic [rsc_pkg::ROM_W-1:0] ROM_LOC_OUT,
   output logic [rsc_pkg::HOST_W-1:0] HOST_ROLE_OUT,
   output logic [rsc_pkg::PORT_W-1:0] PORT_SEL_OUT,
   // Decoded clock multipliers, zero for unsupported codes
   output logic [4:0] PLAT_MULT_OUT,
   output logic [4:0] FIRST_CORE_MULT_OUT,
   output logic [4:0] SECOND_CORE_MULT_OUT,
   output logic [4:0] MEM_MULT_OUT,
   // Decoded boot and role settings
   output logic BOOT_LOCAL_ROM32_OUT,
   output logic ROOT_COMPLEX_ALL_OUT,
   output logic SRIO_X4_3G125_OUT,
   output logic FIRST_CORE_RUN_OUT,
   output logic SECOND_CORE_RUN_OUT,
   output logic BOOT_SEQ_EN_OUT,
   // Decoded memory and Ethernet settings
   output logic MEM_DDR2_OUT,
   output logic MEM_CKE_OUT,
   output logic CTL_EN_OUT,
   output logic [rsc_pkg::ETH_N-1:0] ETH_SERIAL_OUT,
   output logic REFCLK_125_OUT,
   // General reset vector register and status
   output logic [rsc_pkg::VEC_W-1:0] GENERAL_RESET_VECTOR_REGISTER_OUT,
   output logic CONFIG_VALID_OUT
);
   localparam int SEL_W = 4 * RATIO_W + ROM_W + HOST_W + PORT_W + 2 + SEQ_W
      + 3 + ETH_N;
   localparam int RAW_W = SEL_W + VEC_W;

   rsc_state_t state;
   rsc_state_t next_state;
   logic [RAW_W-1:0] pins_raw;
   logic [RAW_W-1:0] pins_sync;
   logic [SEL_W-1:0] drv_sync;
   logic [SEL_W-1:0] drv_raw;
   logic [SEL_W-1:0] dflt;
   logic [SEL_W-1:0] resolved;
   logic [SEL_W-1:0] cap;
   logic [1:0] holdoff_raw;
   logic [1:0] holdoff;
   logic [ETH_N-1:0] eth_raw;
   logic [SEQ_W-1:0] seq;
   logic mem_type;
   logic ctl_en;
   logic [ETH_N-1:0] eth_mode;
   logic refclk;

   // Ratio codes: returns multiplier, zero for codes not supported
   function automatic logic [4:0] ratio_mult(input logic [2:0] code,
                                             input logic [2:0] match,
                                             input logic [4:0] mult);
      ratio_mult = (code == match) ? mult : 5'h00;
   endfunction

   // Value-or-pull-up: undriven bits read as their default
   function automatic logic [SEL_W-1:0] pull(input logic [SEL_W-1:0] v,
                                             input logic [SEL_W-1:0] d,
                                             input logic [SEL_W-1:0] p);
      pull = (v & d) | (p & ~d);
   endfunction

   // Gather pins into one vector so one synchroniser serves them all
   assign holdoff_raw = {FIRST_CORE_BOOT_HOLDOFF_STRAP_IN,
                         SECOND_CORE_BOOT_HOLDOFF_STRAP_IN};
   assign eth_raw = {ETH4_SERIAL_MODE_STRAP_IN, ETH3_SERIAL_MODE_STRAP_IN,
                     ETH2_SERIAL_MODE_STRAP_IN, ETH1_SERIAL_MODE_STRAP_IN};
   assign pins_raw = {GEN_VECTOR_IN,
                      PLAT_RATIO_STRAP_IN, FIRST_CORE_CLOCK_RATIO_STRAP_IN,
                      SECOND_CORE_CLOCK_RATIO_STRAP_IN, MEM_RATIO_STRAP_IN,
                      ROM_LOC_STRAP_IN, HOST_ROLE_STRAP_IN, PORT_SEL_STRAP_IN,
                      holdoff_raw, BOOT_SEQ_STRAP_IN, MEM_TYPE_STRAP_IN,
                      CTL_EN_STRAP_IN, REFCLK_SEL_STRAP_IN, eth_raw};
   // Ratio straps have no pull-up, so they always count as driven
   assign drv_raw = {{(4 * RATIO_W){1'b1}}, ROM_LOC_DRIVEN_IN,
                     HOST_ROLE_DRIVEN_IN, PORT_SEL_DRIVEN_IN,
                     HOLDOFF_DRIVEN_IN, BOOT_SEQ_DRIVEN_IN,
                     MEM_TYPE_DRIVEN_IN, CTL_EN_DRIVEN_IN,
                     REFCLK_SEL_DRIVEN_IN, ETH_MODE_DRIVEN_IN};
   assign dflt = {{(4 * RATIO_W){1'b0}}, ROM_DEFAULT, HOST_DEFAULT,
                  PORT_DEFAULT, HOLDOFF_DEFAULT, SEQ_DEFAULT, MEMTYPE_DEFAULT,
                  CTLEN_DEFAULT, REFCLK_DEFAULT, ETH_DEFAULT};

   // Strap pins come from the board, outside this clock domain
   rsc_sync #(
      .WIDTH(RAW_W)
   ) u_pin_sync (
      .clk_in(CLK_IN),
      .rst_in(1'b0),
      .d_in(pins_raw),
      .q_out(pins_sync)
   );

   rsc_sync #(
      .WIDTH(SEL_W)
   ) u_drv_sync (
      .clk_in(CLK_IN),
      .rst_in(1'b0),
      .d_in(drv_raw),
      .q_out(drv_sync)
   );

   // Undriven pulled-up straps resolve to their default [R4]
   assign resolved = pull(pins_sync[SEL_W-1:0], drv_sync, dflt);

   // Sequencer: reset state throughout reset, then sample and run on the two edges after release [R1]
   always_comb begin
      next_state = state;
      case (state)
         RSC_RESET: next_state = RSC_SAMPLE;
         RSC_SAMPLE: next_state = RSC_RUN;
         RSC_RUN: next_state = RSC_RUN;
         default: next_state = RSC_RESET;
      endcase
   end

   // Reset is the master reset; clocking continues while it is held
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state <= RSC_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Capture runs until two edges after reset falls; the pins must hold to the last edge before release.
   // Async reset cannot load a port, so capture is a plain clocked process
   // gated by the synchronised reset level instead. [R1] [R17]
   logic [1:0] rst_sync;
   always_ff @(posedge CLK_IN) begin
      rst_sync <= {rst_sync[0], RST_IN};
   end

   always_ff @(posedge CLK_IN) begin
      if (rst_sync[1]) begin
         cap <= resolved; // [R1]
         // [R17]
         GENERAL_RESET_VECTOR_REGISTER_OUT <= pins_sync[RAW_W-1:SEL_W];
      end
   end

   // Field split of the captured word
   assign {PLAT_RATIO_OUT, FIRST_CORE_RATIO_OUT, SECOND_CORE_RATIO_OUT,
           MEM_RATIO_OUT, ROM_LOC_OUT, HOST_ROLE_OUT, PORT_SEL_OUT, holdoff,
           seq, mem_type, ctl_en, refclk, eth_mode} = cap;

   // Clock multiplier decode [R5] [R6] [R7]
   assign PLAT_MULT_OUT = ratio_mult(PLAT_RATIO_OUT, RATIO_CODE_X10,
                                     PLAT_MULT_X10); // [R5]
   assign FIRST_CORE_MULT_OUT = ratio_mult(FIRST_CORE_RATIO_OUT,
                                           RATIO_CODE_X2, CORE_MULT_X2); // [R6]
   assign SECOND_CORE_MULT_OUT = ratio_mult(SECOND_CORE_RATIO_OUT,
                                            RATIO_CODE_X2, CORE_MULT_X2); // [R6]
   assign MEM_MULT_OUT = ratio_mult(MEM_RATIO_OUT, RATIO_CODE_X10,
                                    MEM_MULT_X10); // [R7]

   // Boot and role decode
   assign BOOT_LOCAL_ROM32_OUT = (ROM_LOC_OUT == ROM_LOCAL_GPCS32); // [R8]
   assign ROOT_COMPLEX_ALL_OUT = (HOST_ROLE_OUT == HOST_ALL_ROOT); // [R9]
   assign SRIO_X4_3G125_OUT = (PORT_SEL_OUT == PORT_SRIO_X4); // [R10]
   // Cores stay held until configuration is valid [R11]
   assign FIRST_CORE_RUN_OUT = CONFIG_VALID_OUT
      && (holdoff[1] == HOLD_RELEASE); // [R11]
   assign SECOND_CORE_RUN_OUT = CONFIG_VALID_OUT
      && (holdoff[0] == HOLD_RELEASE); // [R11]
   assign BOOT_SEQ_EN_OUT = CONFIG_VALID_OUT
      && (seq != SEQ_DISABLED); // [R12]

   // Memory and Ethernet decode
   assign MEM_DDR2_OUT = (mem_type == MEMTYPE_DDR2); // [R13]
   // Clock enable held low throughout reset for DDR2 [R13]
   assign MEM_CKE_OUT = CONFIG_VALID_OUT || !MEM_DDR2_OUT; // [R13]
   assign CTL_EN_OUT = (ctl_en == 1'b0); // [R14]
   // Ports three and four are forced serial when controller enable is on
   assign ETH_SERIAL_OUT = {(eth_mode[3] == ETH_SERIAL) || CTL_EN_OUT,
                            (eth_mode[2] == ETH_SERIAL) || CTL_EN_OUT,
                            eth_mode[1] == ETH_SERIAL,
                            eth_mode[0] == ETH_SERIAL}; // [R14] [R15]
   assign REFCLK_125_OUT = (refclk == REFCLK_125); // [R16]

   // Configuration is valid once the sequencer has passed sample and reached run
   assign CONFIG_VALID_OUT = (state == RSC_RUN);
endmodule

// File: shared/rsc_pkg.sv
// Package of strap widths, encodings and reset values for the strap loader
package rsc_pkg;
   // Strap field widths
   localparam int RATIO_W = 3;
   localparam int ROM_W = 4;
   localparam int HOST_W = 3;
   localparam int PORT_W = 4;
   localparam int SEQ_W = 2;
   localparam int VEC_W = 32;
   localparam int ETH_N = 4;
   // Pin-side synchroniser depth
   localparam int SYNC_STAGES = 2;
   // Multiplier strap encodings
   localparam logic [2:0] RATIO_CODE_X10 = 3'h4;
   localparam logic [2:0] RATIO_CODE_X2 = 3'h4;
   localparam logic [4:0] PLAT_MULT_X10 = 5'h0A;
   localparam logic [4:0] CORE_MULT_X2 = 5'h02;
   localparam logic [4:0] MEM_MULT_X10 = 5'h0A;
   // Pull-up defaults of straps that have one
   localparam logic [3:0] ROM_DEFAULT = 4'hF;
   localparam logic [2:0] HOST_DEFAULT = 3'h7;
   localparam logic [3:0] PORT_DEFAULT = 4'hF;
   localparam logic [1:0] HOLDOFF_DEFAULT = 2'h3;
   localparam logic [1:0] SEQ_DEFAULT = 2'h3;
   localparam logic MEMTYPE_DEFAULT = 1'b1;
   localparam logic CTLEN_DEFAULT = 1'b1;
   localparam logic [3:0] ETH_DEFAULT = 4'hF;
   localparam logic REFCLK_DEFAULT = 1'b1;
   // Decoded values
   localparam logic [3:0] ROM_LOCAL_GPCS32 = 4'hF;
   localparam logic [2:0] HOST_ALL_ROOT = 3'h7;
   localparam logic [3:0] PORT_SRIO_X4 = 4'hC;
   localparam logic [1:0] SEQ_DISABLED = 2'h3;
   localparam logic MEMTYPE_DDR2 = 1'b0;
   localparam logic ETH_SERIAL = 1'b0;
   localparam logic REFCLK_125 = 1'b1;
   localparam logic HOLD_RELEASE = 1'b1;
   // Loader states
   typedef enum logic [2:0] {
      RSC_RESET = 3'b001,
      RSC_SAMPLE = 3'b010,
      RSC_RUN = 3'b100
   } rsc_state_t;
endpackage

// File: hdl/rsc_sync.sv
// Two-stage synchroniser for a bus of strap pins
`timescale 1ns/1ps
module rsc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Data
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta <= '0;
         q_out <= '0;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule

// File: sim/rsc_board.sv
// Board strap driver model: holds straps across reset, then lets go
`timescale 1ns/1ps
module rsc_board (
   // Clock and master reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Scenario controls
   input wire logic float_in,
   input wire logic [2:0] ratio_in,
   // Strap pins and drive-present flags
   output logic [2:0] ratio_out,
   output logic [21:0] val_out,
   output logic [21:0] drv_out
);
   // Fixed board values; the port strap is the serial link setting
   localparam logic [21:0] BOARD = {4'hF, 3'h7, 4'hC, 2'h2, 2'h3,
      1'h0, 1'h0, 4'h0, 1'h1};
   logic [2:0] hold;
   logic held;
   // Margin after release before shared pins go back to other use
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         hold <= 3'h0;
      end else if (hold != 3'h4) begin
         hold <= hold + 3'h1;
      end
   end
   assign held = rst_in || (hold != 3'h4);
   // Released pins show junk, never the last value
   assign ratio_out = held ? ratio_in : ~ratio_in;
   assign val_out = (held && !float_in) ? BOARD : ~BOARD;
   assign drv_out = (held && !float_in) ? '1 : '0;
endmodule

// File: sim/rsc_loader_chk.sv
// Port assertions for the strap loader
`timescale 1ns/1ps
module rsc_loader_chk
   import rsc_pkg::*;
(
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // Watched outputs
   input wire logic [rsc_pkg::RATIO_W-1:0] PLAT_RATIO_OUT,
   input wire logic [rsc_pkg::RATIO_W-1:0] MEM_RATIO_OUT,
   input wire logic [rsc_pkg::ROM_W-1:0] ROM_LOC_OUT,
   input wire logic [rsc_pkg::PORT_W-1:0] PORT_SEL_OUT,
   input wire logic [4:0] PLAT_MULT_OUT,
   input wire logic [4:0] MEM_MULT_OUT,
   input wire logic BOOT_LOCAL_ROM32_OUT,
   input wire logic SRIO_X4_3G125_OUT,
   input wire logic MEM_DDR2_OUT,
   input wire logic MEM_CKE_OUT,
   input wire logic CTL_EN_OUT,
   input wire logic [rsc_pkg::ETH_N-1:0] ETH_SERIAL_OUT,
   input wire logic [rsc_pkg::VEC_W-1:0] GENERAL_RESET_VECTOR_REGISTER_OUT,
   input wire logic CONFIG_VALID_OUT
);
   logic [1:0] age;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   // Edges since release, saturating
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   AST_VALID_TIME: assert property
      (CONFIG_VALID_OUT == (age >= 2'h2))
      else $error("valid flag out of step");
   AST_PLAT_MULT: assert property (PLAT_MULT_OUT ==
      (PLAT_RATIO_OUT == 3'h4 ? 5'h0A : 5'h00)) else $error("plat mult");
   AST_MEM_MULT: assert property (MEM_MULT_OUT ==
      (MEM_RATIO_OUT == 3'h4 ? 5'h0A : 5'h00)) else $error("mem mult");
   AST_ROM: assert property
      (BOOT_LOCAL_ROM32_OUT == (ROM_LOC_OUT == 4'hF))
      else $error("rom decode");
   AST_PORT: assert property
      (SRIO_X4_3G125_OUT == (PORT_SEL_OUT == 4'hC))
      else $error("port decode");
   AST_FROZEN: assert property
      (CONFIG_VALID_OUT ##1 CONFIG_VALID_OUT |->
      $stable({GENERAL_RESET_VECTOR_REGISTER_OUT, ROM_LOC_OUT}))
      else $error("capture moved");
   AST_CKE: assert property (MEM_DDR2_OUT && !CONFIG_VALID_OUT |->
      !MEM_CKE_OUT) else $error("clock enable high early");
   AST_CTL_ETH: assert property
      (CTL_EN_OUT |-> ETH_SERIAL_OUT[3:2] == 2'h3)
      else $error("ports three and four not serial");
   // Main scenarios reached
   cover property (SRIO_X4_3G125_OUT && CONFIG_VALID_OUT);
   cover property (CTL_EN_OUT && CONFIG_VALID_OUT);
   cover property ($rose(CONFIG_VALID_OUT) && !MEM_DDR2_OUT);
endmodule
bind rsc_loader rsc_loader_chk chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .PLAT_RATIO_OUT(PLAT_RATIO_OUT), .MEM_RATIO_OUT(MEM_RATIO_OUT),
   .ROM_LOC_OUT(ROM_LOC_OUT), .PORT_SEL_OUT(PORT_SEL_OUT),
   .PLAT_MULT_OUT(PLAT_MULT_OUT), .MEM_MULT_OUT(MEM_MULT_OUT),
   .BOOT_LOCAL_ROM32_OUT(BOOT_LOCAL_ROM32_OUT),
   .SRIO_X4_3G125_OUT(SRIO_X4_3G125_OUT), .MEM_DDR2_OUT(MEM_DDR2_OUT),
   .MEM_CKE_OUT(MEM_CKE_OUT), .CTL_EN_OUT(CTL_EN_OUT),
   .ETH_SERIAL_OUT(ETH_SERIAL_OUT), .CONFIG_VALID_OUT(CONFIG_VALID_OUT),
   .GENERAL_RESET_VECTOR_REGISTER_OUT(GENERAL_RESET_VECTOR_REGISTER_OUT));

// File: sim/rsc_loader_test.sv
// Self-checking bench for the strap loader
`timescale 1ns/1ps
module rsc_loader_test;
   import rsc_pkg::*;
   logic clk, rst, flt, b_rom, root, srio, run0, run1, seq_en;
   logic ddr2, cke, ctl, ref125, valid;
   logic [2:0] ratio, ratio_pin, plat_r, c0_r, c1_r, mem_r, host;
   logic [3:0] rom, port, eth;
   logic [4:0] m0, m1, m2, m3;
   logic [21:0] v, d;
   logic [31:0] vec, gvec;
   int n_fail, n_checks, cycles;
   rsc_board board (.clk_in(clk), .rst_in(rst), .float_in(flt),
      .ratio_in(ratio), .ratio_out(ratio_pin), .val_out(v), .drv_out(d));
   rsc_loader DUT (.CLK_IN(clk), .RST_IN(rst),
      .PLAT_RATIO_STRAP_IN(ratio_pin),
      .FIRST_CORE_CLOCK_RATIO_STRAP_IN(ratio_pin),
      .SECOND_CORE_CLOCK_RATIO_STRAP_IN(ratio_pin),
      .MEM_RATIO_STRAP_IN(ratio_pin),
      .ROM_LOC_STRAP_IN(v[21:18]), .ROM_LOC_DRIVEN_IN(d[21:18]),
      .HOST_ROLE_STRAP_IN(v[17:15]), .HOST_ROLE_DRIVEN_IN(d[17:15]),
      .PORT_SEL_STRAP_IN(v[14:11]), .PORT_SEL_DRIVEN_IN(d[14:11]),
      .FIRST_CORE_BOOT_HOLDOFF_STRAP_IN(v[10]),
      .SECOND_CORE_BOOT_HOLDOFF_STRAP_IN(v[9]), .HOLDOFF_DRIVEN_IN(d[10:9]),
      .BOOT_SEQ_STRAP_IN(v[8:7]), .BOOT_SEQ_DRIVEN_IN(d[8:7]),
      .MEM_TYPE_STRAP_IN(v[6]), .MEM_TYPE_DRIVEN_IN(d[6]),
      .CTL_EN_STRAP_IN(v[5]), .CTL_EN_DRIVEN_IN(d[5]),
      .ETH1_SERIAL_MODE_STRAP_IN(v[1]), .ETH2_SERIAL_MODE_STRAP_IN(v[2]),
      .ETH3_SERIAL_MODE_STRAP_IN(v[3]), .ETH4_SERIAL_MODE_STRAP_IN(v[4]),
      .ETH_MODE_DRIVEN_IN(d[4:1]), .REFCLK_SEL_STRAP_IN(v[0]),
      .REFCLK_SEL_DRIVEN_IN(d[0]), .GEN_VECTOR_IN(vec),
      .PLAT_RATIO_OUT(plat_r), .FIRST_CORE_RATIO_OUT(c0_r),
      .SECOND_CORE_RATIO_OUT(c1_r), .MEM_RATIO_OUT(mem_r),
      .ROM_LOC_OUT(rom), .HOST_ROLE_OUT(host), .PORT_SEL_OUT(port),
      .PLAT_MULT_OUT(m0), .FIRST_CORE_MULT_OUT(m1),
      .SECOND_CORE_MULT_OUT(m2), .MEM_MULT_OUT(m3),
      .BOOT_LOCAL_ROM32_OUT(b_rom), .ROOT_COMPLEX_ALL_OUT(root),
      .SRIO_X4_3G125_OUT(srio), .FIRST_CORE_RUN_OUT(run0),
      .SECOND_CORE_RUN_OUT(run1), .BOOT_SEQ_EN_OUT(seq_en),
      .MEM_DDR2_OUT(ddr2), .MEM_CKE_OUT(cke), .CTL_EN_OUT(ctl),
      .ETH_SERIAL_OUT(eth), .REFCLK_125_OUT(ref125),
      .GENERAL_RESET_VECTOR_REGISTER_OUT(gvec), .CONFIG_VALID_OUT(valid));
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e,
         input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   // Controls change one edge before reset rises; once reset is high the board drives the straps, or floats the pulled-up ones when f is set
   task automatic run_reset(input logic f, input logic [2:0] r,
         input logic [31:0] x);
      @(posedge clk);
      flt <= f;
      ratio <= r;
      vec <= x;
      @(posedge clk);
      rst <= 1'h1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("valid in reset", 32'h0, {31'h0, valid});
      if (!f) chk("cke in reset", 32'h0, {31'h0, cke});
      @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   // Clock at 10 MHz
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   // Hang guard: the whole run needs well under a hundred cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 500) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      rst = 1'h1;
      flt = 1'h0;
      ratio = 3'h4;
      vec = 32'h0;
      n_fail = 0;
      n_checks = 0;
      cycles = 0;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      // Board settings with supported ratios
      run_reset(1'h0, 3'h4, 32'hA5C3_0F81);
      chk("mults", {12'h0, 5'h0A, 5'h02, 5'h02, 5'h0A},
         {12'h0, m0, m1, m2, m3});
      chk("rom host port", {21'h0, 4'hF, 3'h7, 4'hC},
         {21'h0, rom, host, port});
      chk("flags", {19'h0, 9'h1E7, 4'hF},
         {19'h0, b_rom, root, srio, run0, run1, seq_en, ddr2, ctl, ref125,
         eth});
      chk("cke after valid", 32'h1, {31'h0, cke});
      chk("vector", 32'hA5C3_0F81, gvec);
      // Pins released and changed after the freeze must be ignored
      @(posedge clk);
      vec <= 32'h5A3C_F07E;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("vector held", 32'hA5C3_0F81, gvec);
      chk("held", {16'h0, 4'hF, 4'hC, 3'h4, 5'h0A},
         {16'h0, rom, port, plat_r, m0});
      // Second reset mid-run, all pulled-up straps left floating
      run_reset(1'h1, 3'h5, 32'h0123_4567);
      chk("mults float", 32'h0, {12'h0, m0, m1, m2, m3});
      chk("raw float", {9'h0, 12'hB6D, 4'hF, 3'h7, 4'hF},
         {9'h0, plat_r, c0_r, c1_r, mem_r, rom, host, port});
      chk("flags float", {19'h0, 9'h1B1, 4'h0},
         {19'h0, b_rom, root, srio, run0, run1, seq_en, ddr2, ctl, ref125,
         eth});
      chk("vector float", 32'h0123_4567, gvec);
      close_out();
   end
endmodule
